// >>> src/ata_qpc_consts.svh
/*
 Named constants of the queued-command and power-mode controller.
 Included by the package file only; definitions only.
*/
`ifndef ATA_QPC_CONSTS_SVH
`define ATA_QPC_CONSTS_SVH

// Queue geometry and timer width.
`define QDEPTH 4
`define QIDX_W 2
`define TAG_W 5
`define TMR_W 40

// APB register byte addresses.
`define ADDR_CMD 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_RESULT 8'h0c
`define ADDR_INFO 8'h10

// Command word fields.
`define CMD_OP 7:0
`define CMD_CNT 15:8
`define CMD_FEAT 23:16
`define CMD_TAG 12:8

// Status word bit positions.
`define ST_ERR 0
`define ST_DRQ 3
`define ST_SERV 4
`define ST_RDY 6
`define ST_BSY 7
`define ST_PEND 8

// Control word bit positions.
`define CTL_NIEN 0
`define CTL_SEL 1

// Result and info word fields.
`define RES_VAL 7:0
`define RES_QV 11:8
`define RES_QR 15:12
`define INF_DEPTH 4:0
`define INF_PM 9:8
`define INF_IFACE 10
`define INF_MEDIA 11

// Command opcodes and the overlapped NOP subcommand.
`define OP_NOP 8'h00
`define NOP_SUB_OVL 8'h01
`define OP_RD_Q 8'hc7
`define OP_SVC 8'ha2
`define OP_WR_Q 8'hcc
`define OP_STBY_IMM 8'he0
`define OP_IDLE_IMM 8'he1
`define OP_STBY 8'he2
`define OP_IDLE 8'he3
`define OP_CHK_PWR 8'he5
`define OP_SLEEP 8'he6

// Power mode check answers and the timer-off count.
`define PWR_CODE_STBY 8'h00
`define PWR_CODE_IDLE 8'h80
`define PWR_CODE_ACT 8'hff
`define TMR_OFF_CNT 8'h00

// Reset values and the reported maximum queue depth.
`define RST_SEL 1'b1
`define MAX_DEPTH 5'h04

`endif

// >>> src/ata_qpc_pkg.sv
/*
 Types of the queued-command and power-mode controller.
 Assumes the constants header is on the include path.
*/
`include "ata_qpc_consts.svh"

package ata_qpc_pkg;

   typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_STANDBY, PM_SLEEP}
      pwr_mode_t;

   typedef enum logic {EX_IDLE, EX_BUSY} exec_t;

   typedef struct packed {
      pwr_mode_t pm;
      exec_t ex;
      logic err;
      logic pend;
      logic nien;
      logic sel;
      logic [7:0] result;
      logic [`QDEPTH-1:0] qv;
      logic [`QDEPTH-1:0] qr;
      logic [`QDEPTH-1:0][`TAG_W-1:0] qtag;
      logic tmr_en;
      logic [7:0] tmr_cnt;
      logic [`TMR_W-1:0] tmr;
      logic [31:0] prdata;
   } state_t;

   parameter state_t STATE_RST = '{pm: PM_IDLE, ex: EX_IDLE,
      sel: `RST_SEL, default: '0};

endpackage : ata_qpc_pkg

// >>> src/ata_queue_power_control.sv
/*
 Device-side command control of a disk drive host interface: overlapped
 and queued commands with service requests and the interrupt line, and
 the power-mode machine with its standby timer, reached over APB.
 Assumes one 100 MHz clock, a host that keeps the overlap protocol, and
 a media back end that reports completion and readiness by pulses.
*/
// Implementation choices: register access over APB and the placing of the registers.
// Overview of operation
// - Bus release clears BSY; DRQ follows the drq_i input and is not cleared.
// - Only overlapped NOP, queued read, service, queued write overlap.
// - Queued transfer starts executing at once if ready, else releases the bus.
// - Non-overlapped command with a queue present is aborted, queue flushed.
// - Maximum queue depth is reported in the identification word.
// - Service restores the tag of the command being serviced.
// - Duplicate tag aborts the whole queue including the new command.
// - Any error while queued aborts the whole queue.
// - Ready while bus idle: set SERV, pending, interrupt if enabled.
// - SERV stays set while any command awaits service.
// - Status read or command write clears pending and interrupt.
// - Ready while busy sets only SERV; no more interrupts until clear.
// - New command runs its own protocol; SERV kept, no extra interrupt.
// - Power check reports active, idle or standby.
// - Idle commands enter idle; plain idle loads and starts the timer.
// - Standby commands enter standby; plain standby loads the timer.
// - Sleep deactivates the interface; device reset leaves to standby, hard reset to idle.
// - Timer expiry in active or idle enters standby.
// - Count zero on idle or standby disables the timer.
// - Idle, standby, sleep show BSY 0, RDY 1; media per mode.
// - Device reset moves sleep to standby, else keeps mode; hard reset enters idle.
`timescale 1ns/10ps

module ata_queue_power_control #(
   parameter logic [`TMR_W-1:0] TIMER_UNIT_CYCLES = 40'h00_1dcd_6500
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Host link events
   input wire logic dev_reset_i,
   input wire logic drq_i,
   // Media back end
   input wire logic qcmd_ready_i,
   input wire logic media_done_i,
   input wire logic media_err_i,
   input wire logic svc_ready_i,
   input wire logic [`TAG_W-1:0] svc_tag_i,
   // Status to the host side
   output logic intrq_o,
   output logic bsy_o,
   output logic serv_o,
   output logic [1:0] power_mode_o,
   output logic iface_active_o,
   output logic media_active_o
);

   ata_qpc_pkg::state_t s;
   ata_qpc_pkg::state_t n;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [`QDEPTH-1:0] dup;
   logic [`QDEPTH-1:0] hit;
   logic [`TAG_W-1:0] new_tag;

   function automatic logic [`TMR_W-1:0] period_f(input logic [7:0] c);
      period_f = `TMR_W'(c) * TIMER_UNIT_CYCLES;
   endfunction : period_f

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];
   assign new_tag = pwdata_i[`CMD_TAG];

   for (genvar i = 0; i < `QDEPTH; i++)
   begin : g_ent
      assign dup[i] = s.qv[i] & (s.qtag[i] == new_tag);
      assign hit[i] = s.qv[i] & (s.qtag[i] == svc_tag_i);
   end

   always_comb
   begin
      logic busy;
      logic iface;
      logic done;
      logic wr;
      logic rd;
      logic queued;
      logic ovl;
      logic flush;
      logic [7:0] op;
      logic [7:0] cnt;
      logic [`QIDX_W-1:0] rix;
      logic [`QIDX_W-1:0] fix;
      logic full;
      busy = (s.ex == ata_qpc_pkg::EX_BUSY) | drq_i;
      iface = s.pm != ata_qpc_pkg::PM_SLEEP;
      done = psel_i & penable_i;
      wr = done & pwrite_i;
      rd = done & ~pwrite_i;
      op = pwdata_i[`CMD_OP];
      cnt = pwdata_i[`CMD_CNT];
      queued = (op == `OP_RD_Q) | (op == `OP_WR_Q);
      ovl = queued | (op == `OP_SVC) |
         ((op == `OP_NOP) & (pwdata_i[`CMD_FEAT] == `NOP_SUB_OVL));
      flush = 1'b0;
      full = &s.qv;
      rix = '0;
      fix = '0;
      for (int k = `QDEPTH - 1; k >= 0; k--)
      begin
         if (s.qr[k])
         begin
            rix = `QIDX_W'(k);
         end
         if (!s.qv[k])
         begin
            fix = `QIDX_W'(k);
         end
      end
      n = s;

      // Clears by the host come first so that a same-cycle event wins.
      if ((rd && paddr_i == `ADDR_STATUS) ||
         (wr && paddr_i == `ADDR_CMD && iface))
      begin
         n.pend = 1'b0;
      end
      if (wr && paddr_i == `ADDR_CTRL)
      begin
         n.nien = pwdata_i[`CTL_NIEN];
         n.sel = pwdata_i[`CTL_SEL];
      end

      // Standby timer runs only while nothing is executing.
      if (s.tmr_en && !busy && (s.pm == ata_qpc_pkg::PM_ACTIVE ||
         s.pm == ata_qpc_pkg::PM_IDLE))
      begin
         if (s.tmr <= `TMR_W'(1))
         begin
            n.pm = ata_qpc_pkg::PM_STANDBY;
            n.tmr = '0;
         end
         else
         begin
            n.tmr = s.tmr - `TMR_W'(1);
         end
      end

      if (media_done_i && s.ex == ata_qpc_pkg::EX_BUSY)
      begin
         n.ex = ata_qpc_pkg::EX_IDLE;
         n.pend = 1'b1;
         if (media_err_i)
         begin
            n.err = 1'b1;
            flush = 1'b1;
         end
      end

      if (svc_ready_i && (hit != '0))
      begin
         n.qr = s.qr | hit;
         if (s.qr == '0 && !busy)
         begin
            n.pend = 1'b1;
         end
      end

      if (wr && paddr_i == `ADDR_CMD && iface)
      begin
         n.err = 1'b0;
         if (s.tmr_en)
         begin
            n.tmr = period_f(s.tmr_cnt);
         end
         if (!ovl && s.qv != '0)
         begin
            n.err = 1'b1;
            n.pend = 1'b1;
            flush = 1'b1;
         end
         else if (queued)
         begin
            if (dup != '0 || (full && !qcmd_ready_i))
            begin
               n.err = 1'b1;
               n.pend = 1'b1;
               flush = 1'b1;
            end
            else if (qcmd_ready_i)
            begin
               n.ex = ata_qpc_pkg::EX_BUSY;
               n.pm = ata_qpc_pkg::PM_ACTIVE;
            end
            else
            begin
               n.qv[fix] = 1'b1;
               n.qtag[fix] = new_tag;
               n.ex = ata_qpc_pkg::EX_IDLE;
            end
         end
         else if (op == `OP_SVC)
         begin
            if (s.qr != '0)
            begin
               n.result = 8'(s.qtag[rix]);
               n.qv[rix] = 1'b0;
               n.qr[rix] = 1'b0;
               n.ex = ata_qpc_pkg::EX_BUSY;
               n.pm = ata_qpc_pkg::PM_ACTIVE;
            end
            else
            begin
               n.err = 1'b1;
               n.pend = 1'b1;
               flush = 1'b1;
            end
         end
         else if (ovl)
         begin
            n.pend = 1'b1;
         end
         else
         begin
            n.pend = 1'b1;
            case (op)
               `OP_IDLE, `OP_STBY:
               begin
                  n.pm = (op == `OP_IDLE) ? ata_qpc_pkg::PM_IDLE :
                     ata_qpc_pkg::PM_STANDBY;
                  n.tmr_cnt = cnt;
                  n.tmr_en = cnt != `TMR_OFF_CNT;
                  n.tmr = period_f(cnt);
               end
               `OP_IDLE_IMM:
               begin
                  n.pm = ata_qpc_pkg::PM_IDLE;
               end
               `OP_STBY_IMM:
               begin
                  n.pm = ata_qpc_pkg::PM_STANDBY;
               end
               `OP_SLEEP:
               begin
                  n.pm = ata_qpc_pkg::PM_SLEEP;
               end
               `OP_CHK_PWR:
               begin
                  case (s.pm)
                     ata_qpc_pkg::PM_ACTIVE: n.result = `PWR_CODE_ACT;
                     ata_qpc_pkg::PM_IDLE: n.result = `PWR_CODE_IDLE;
                     default: n.result = `PWR_CODE_STBY;
                  endcase
               end
               default:
               begin
                  n.pend = 1'b0;
                  n.ex = ata_qpc_pkg::EX_BUSY;
                  n.pm = ata_qpc_pkg::PM_ACTIVE;
               end
            endcase
         end
      end

      if (flush)
      begin
         n.qv = '0;
         n.qr = '0;
      end

      if (dev_reset_i)
      begin
         n.ex = ata_qpc_pkg::EX_IDLE;
         n.pend = 1'b0;
         n.err = 1'b0;
         n.qv = '0;
         n.qr = '0;
         if (s.pm == ata_qpc_pkg::PM_SLEEP)
         begin
            n.pm = ata_qpc_pkg::PM_STANDBY;
         end
      end

      // Read data is captured in the setup cycle for the access cycle.
      n.prdata = '0;
      case (paddr_i)
         `ADDR_STATUS:
         begin
            n.prdata[`ST_ERR] = s.err;
            n.prdata[`ST_DRQ] = drq_i;
            n.prdata[`ST_SERV] = s.qr != '0;
            n.prdata[`ST_RDY] = 1'b1;
            n.prdata[`ST_BSY] = s.ex == ata_qpc_pkg::EX_BUSY;
            n.prdata[`ST_PEND] = s.pend;
         end
         `ADDR_CTRL:
         begin
            n.prdata[`CTL_NIEN] = s.nien;
            n.prdata[`CTL_SEL] = s.sel;
         end
         `ADDR_RESULT:
         begin
            n.prdata[`RES_VAL] = s.result;
            n.prdata[`RES_QV] = s.qv;
            n.prdata[`RES_QR] = s.qr;
         end
         `ADDR_INFO:
         begin
            n.prdata[`INF_DEPTH] = `MAX_DEPTH;
            n.prdata[`INF_PM] = s.pm;
            n.prdata[`INF_IFACE] = iface;
            n.prdata[`INF_MEDIA] = s.pm == ata_qpc_pkg::PM_ACTIVE ||
               s.pm == ata_qpc_pkg::PM_IDLE;
         end
         default:
         begin
            n.prdata = '0;
         end
      endcase
      if (!(psel_i && !penable_i))
      begin
         n.prdata = s.prdata;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= ata_qpc_pkg::STATE_RST;
      end
      else
      begin
         s <= n;
      end
   end

   assign prdata_o = s.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~(paddr_i == `ADDR_CMD ||
      paddr_i == `ADDR_STATUS || paddr_i == `ADDR_CTRL ||
      paddr_i == `ADDR_RESULT || paddr_i == `ADDR_INFO);
   assign intrq_o = s.pend & s.sel & ~s.nien;
   assign bsy_o = s.ex == ata_qpc_pkg::EX_BUSY;
   assign serv_o = s.qr != '0;
   assign power_mode_o = s.pm;
   assign iface_active_o = s.pm != ata_qpc_pkg::PM_SLEEP;
   assign media_active_o = s.pm == ata_qpc_pkg::PM_ACTIVE ||
      s.pm == ata_qpc_pkg::PM_IDLE;

endmodule : ata_queue_power_control

// >>> src/unused_placeholder_removed.sv
/*
 Holds no logic: the whole controller lives in its own module file.
 Assumes nothing of its surroundings.
*/

// >>> verif/ata_qpc_chk.sv
/*
 Port assertions of the queue and power-mode controller.
 Bound to the top module; sees only its ports.
*/
`timescale 1ns/10ps
module ata_qpc_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Bus and events
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic dev_reset_i,
   input wire logic qcmd_ready_i,
   input wire logic media_done_i,
   input wire logic media_err_i,
   input wire logic svc_ready_i,
   // Status
   input wire logic intrq_o,
   input wire logic bsy_o,
   input wire logic serv_o,
   input wire logic [1:0] power_mode_o,
   input wire logic iface_active_o,
   input wire logic media_active_o
);
   logic acc;
   logic wcmd;
   logic rsts;
   assign acc = psel_i & penable_i;
   assign wcmd = acc & pwrite_i & (paddr_i == 8'h00);
   assign rsts = acc & !pwrite_i & (paddr_i == 8'h04);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_ready;
      acc |-> pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_unmapped;
      acc |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c,
         8'h10});
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("pslverr wrong");
   property p_iface;
      iface_active_o == (power_mode_o != 2'h3);
   endproperty
   a_iface: assert property (p_iface) else $error("iface wrong");
   property p_media;
      media_active_o == !power_mode_o[1];
   endproperty
   a_media: assert property (p_media) else $error("media wrong");
   property p_sleep_bsy;
      power_mode_o == 2'h3 |-> !bsy_o;
   endproperty
   a_sleep_bsy: assert property (p_sleep_bsy) else $error("bsy in sleep");
   property p_stay;
      power_mode_o == 2'h3 && !dev_reset_i |=> power_mode_o == 2'h3;
   endproperty
   a_stay: assert property (p_stay) else $error("left sleep");
   property p_wake;
      power_mode_o == 2'h3 && dev_reset_i |=> power_mode_o == 2'h2;
   endproperty
   a_wake: assert property (p_wake) else $error("wake wrong");
   property p_release;
      wcmd && pwdata_i[7:0] == 8'hc7 && !qcmd_ready_i && !bsy_o &&
         power_mode_o != 2'h3 |=> !bsy_o [*2];
   endproperty
   a_release: assert property (p_release) else $error("no release");
   property p_clear;
      rsts && !svc_ready_i && !media_done_i && !dev_reset_i |=> !intrq_o;
   endproperty
   a_clear: assert property (p_clear) else $error("intrq kept");
   property p_serv;
      serv_o && !wcmd && !dev_reset_i && !(media_done_i && media_err_i)
         |=> serv_o;
   endproperty
   a_serv: assert property (p_serv) else $error("serv dropped");
endmodule : ata_qpc_chk

bind ata_queue_power_control ata_qpc_chk i_chk (.*);

// >>> verif/ata_media_model.sv
/*
 Media back end model: finishes a busy command after a set latency.
 Assumes busy falls once done has been seen.
*/
`timescale 1ns/10ps
module ata_media_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic busy_i,
   input wire logic [7:0] lat_i,
   input wire logic fail_i,
   // Completion
   output logic done_o,
   output logic err_o
);
   logic [7:0] cnt_q;
   // The error line carries no meaning outside done, so it is scrambled.
   assign err_o = done_o ? fail_i : !fail_i;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 8'h00;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         cnt_q <= 8'h00;
         if (busy_i && !done_o)
         begin
            cnt_q <= cnt_q + 8'h01;
            done_o <= cnt_q >= lat_i;
         end
      end
   end
endmodule : ata_media_model

// >>> verif/test_ata_queue_power_control.sv
/*
 Self-checking bench of the queue and power-mode controller.
 Assumes the design, checker and media model are compiled first.
*/
`timescale 1ns/10ps
module test_ata_queue_power_control;
   logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
   logic pwrite_i = 0, dev_reset_i = 0, drq_i = 0, qcmd_ready_i = 0;
   logic svc_ready_i = 0, pready_o, pslverr_o, intrq_o, bsy_o, serv_o;
   logic media_done_i, media_err_i, iface_active_o, media_active_o;
   logic fail = 0;
   logic [7:0] paddr_i = 8'h00, lat = 8'h14;
   logic [4:0] svc_tag_i = 5'h00;
   logic [1:0] power_mode_o;
   logic [31:0] pwdata_i = 32'h0, prdata_o, q;
   int failures = 0, check_count = 0, cyc = 0;
   logic [41:0] rows [5] = '{{32'he1, 2'h1, 8'h80}, {32'he0, 2'h2, 8'h00},
      {32'he3, 2'h1, 8'h80}, {32'he2, 2'h2, 8'h00}, {32'he1, 2'h1, 8'h80}};
   always #5 ref_clk_i = ~ref_clk_i;
   ata_queue_power_control #(.TIMER_UNIT_CYCLES(40'h0a)) i_dut (.*);
   ata_media_model i_media (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .busy_i(bsy_o), .lat_i(lat), .fail_i(fail), .done_o(media_done_i),
      .err_o(media_err_i));
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      while (pready_o !== 1'b1) @(posedge ref_clk_i);
      q = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick
   task svc(input logic [4:0] t);
      @(posedge ref_clk_i);
      svc_ready_i <= 1'b1;
      svc_tag_i <= t;
      @(posedge ref_clk_i);
      svc_ready_i <= 1'b0;
   endtask : svc
   task wbsy;
      int k;
      k = 0;
      while (bsy_o === 1'b1 && k < 100)
      begin
         @(posedge ref_clk_i);
         k++;
      end
      tick(1);
      cmp("bsy end", 0, 32'(bsy_o));
   endtask : wbsy
   task end_of_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      apb(1, 8'h08, 32'h2);
      foreach (rows[i])
      begin
         apb(1, 8'h00, rows[i][41:10]);
         apb(0, 8'h10, 0);
         cmp("mode", 32'(rows[i][9:8]), 32'(q[9:8]));
         apb(1, 8'h00, 32'he5);
         apb(0, 8'h0c, 0);
         cmp("power code", 32'(rows[i][7:0]), 32'(q[7:0]));
         $display("row %0d done", i);
      end
      apb(1, 8'h00, 32'h2e3);
      tick(10);
      cmp("timer early", 1, 32'(power_mode_o));
      tick(20);
      cmp("timer out", 2, 32'(power_mode_o));
      apb(1, 8'h00, 32'he3);
      tick(40);
      cmp("timer off", 1, 32'(power_mode_o));
      apb(0, 8'h14, 0);
      cmp("unmapped", 0, q);
      $display("timer test done");
      apb(1, 8'h00, 32'he6);
      apb(1, 8'h00, 32'he1);
      apb(0, 8'h10, 0);
      cmp("sleep info", 3, 32'(q[11:8]));
      apb(0, 8'h04, 0);
      cmp("sleep flags", 1, 32'(q[7:6]));
      dev_reset_i <= 1'b1;
      tick(1);
      dev_reset_i <= 1'b0;
      tick(1);
      cmp("wake", 2, 32'(power_mode_o));
      $display("sleep test done");
      apb(1, 8'h08, 32'h3);
      apb(1, 8'h00, 32'h3c7);
      apb(1, 8'h08, 32'h2);
      cmp("release", 0, 32'(bsy_o));
      svc(5'h03);
      tick(2);
      cmp("serv", 1, 32'(serv_o));
      cmp("intrq", 1, 32'(intrq_o));
      apb(0, 8'h04, 0);
      cmp("status", 32'h150, 32'(q[8:0]));
      tick(1);
      cmp("intrq clear", 0, 32'(intrq_o));
      apb(1, 8'h00, 32'ha2);
      tick(1);
      cmp("svc bsy", 1, 32'(bsy_o));
      apb(0, 8'h0c, 0);
      cmp("tag", 3, 32'(q[15:0]));
      wbsy();
      cmp("serv done", 0, 32'(serv_o));
      apb(1, 8'h00, 32'h1c7);
      apb(0, 8'h04, 0);
      drq_i <= 1'b1;
      svc(5'h01);
      tick(2);
      cmp("serv busy", 1, 32'(serv_o));
      cmp("no intrq", 0, 32'(intrq_o));
      drq_i <= 1'b0;
      apb(1, 8'h00, 32'he5);
      apb(0, 8'h04, 0);
      cmp("abort err", 1, 32'(q[0]));
      apb(0, 8'h0c, 0);
      cmp("flushed", 0, 32'(q[11:8]));
      apb(1, 8'h00, 32'h5c7);
      apb(1, 8'h00, 32'h5cc);
      apb(0, 8'h04, 0);
      cmp("dup err", 1, 32'(q[0]));
      apb(0, 8'h0c, 0);
      cmp("dup flush", 0, 32'(q[11:8]));
      qcmd_ready_i <= 1'b1;
      apb(1, 8'h00, 32'h7c7);
      tick(1);
      cmp("now bsy", 1, 32'(bsy_o));
      wbsy();
      $display("queue test done");
      end_of_test();
   end
endmodule : test_ata_queue_power_control
